// ---- verilog/mrc_defs.svh ----
// Constants for the multiport repeater core
`ifndef MRC_DEFS_SVH
`define MRC_DEFS_SVH

`define MRC_PORTS 9
`define MRC_AUI_PORT 0
`define MRC_CLK_NS 25
`define MRC_BIT_NS 100
`define MRC_FIFO_DEPTH 32
`define MRC_PRE_BITS 64
`define MRC_SFD_POS 62
`define MRC_JAM_BITS 96
`define MRC_IPG_BITS 96
`define MRC_GOOD_BITS 512
`define MRC_LOOP_BITS 256
`define MRC_COL_LIMIT 64
`define MRC_LINK_LIMIT 2
`define MRC_GOOD_TX 4
`define MRC_LONG_COL_NS 200000

`endif

// ---- verilog/mrc_pkg.sv ----
// Types shared by the multiport repeater core
`default_nettype none

package mrc_pkg;

  typedef enum logic [2:0] {
    MRC_IDLE = 3'b000,
    MRC_PRE  = 3'b001,
    MRC_DATA = 3'b010,
    MRC_JAM  = 3'b011,
    MRC_WAIT = 3'b100
  } mrc_state_e;

  // Per-port observations gathered over one repeated frame
  typedef struct packed {
    logic tx;
    logic car;
    logic lf;
    logic col;
  } mrc_port_s;

endpackage : mrc_pkg

`default_nettype wire

// ---- verilog/mrc_fifo_mem.sv ----
// Dual-clock storage for the repeat buffer, registered read port
`timescale 1ns/10ps
`default_nettype none

module mrc_fifo_mem #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input wire logic i_wr_clk,
  input wire logic i_wr_en,
  input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic i_rd_clk,
  input wire logic i_rd_reset,
  input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_wr_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_rd_clk or posedge i_rd_reset) begin
    if (i_rd_reset) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule : mrc_fifo_mem

`default_nettype wire

// ---- verilog/mrc_core.sv ----
// Repeater core: port arbitration, preamble regeneration, jam and partitioning
// Behaviour
// - Nine alike ports, port 0 is AUI
// - Filtered carrier picks receive port and mux
// - Signal on one port starts preamble elsewhere
// - Send full regenerated 64-bit preamble unless a collision switches to jam
// - Replicate data only after incoming preamble ends
// - 32-bit buffer holds data during preamble
// - Watch collisions on all unpartitioned ports, enforce on all but the colliding ones
// - Collision on transmit port jams other ports
// - Jam lasts 96 bits and until collision ends
// - Receive-port collision jams all but that port
// - Mode interval wait after jam ends
// - Partitioned port not repeated, still transmitted to
// - Error-free 512-bit transfer reconnects partitioned port
// - 64 successive collisions partition; clean transmit clears
// - No loopback within 256 bits partitions port
// - Carrier drop without collision is link fault
// - Two consecutive link faults partition port
// - Collision clears consecutive link-fault count
// - Collision reconnects link-partitioned port
// - Four good transmissions reconnect link-partitioned port
// - Collision longer than 200 us partitions port
// - Preamble and data go only to selected ports
`timescale 1ns/10ps
`default_nettype none
`include "mrc_defs.svh"

module mrc_core import mrc_pkg::*; #(
  parameter int PORTS = `MRC_PORTS,
  parameter int FIFO_DEPTH = `MRC_FIFO_DEPTH,
  parameter int IPG_BITS = `MRC_IPG_BITS,
  parameter int LONG_COL_CYC = (`MRC_LONG_COL_NS + `MRC_CLK_NS - 1) / `MRC_CLK_NS
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_rx_clk,
  input wire logic i_rx_data,
  input wire logic i_rx_dv,
  input wire logic [PORTS-1:0] i_carrier,
  input wire logic [PORTS-1:0] i_collision,
  output logic [$clog2(PORTS)-1:0] o_rx_sel,
  output logic [PORTS-1:0] o_tx_en,
  output logic o_tx_data,
  output logic o_tx_strobe,
  output logic [PORTS-1:0] o_partitioned
);

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int SW = $clog2(PORTS);
  localparam int BIT_CYC = `MRC_BIT_NS / `MRC_CLK_NS;
  localparam int LCW = $clog2(LONG_COL_CYC + 2);
  localparam logic [9:0] PRE_LAST = 10'(`MRC_PRE_BITS - 1);
  localparam logic [9:0] SFD_POS = 10'(`MRC_SFD_POS);
  localparam logic [9:0] JAM_LAST = 10'(`MRC_JAM_BITS - 1);
  localparam logic [9:0] IPG_LAST = 10'(IPG_BITS - 1);
  localparam logic [9:0] GOOD_BITS = 10'(`MRC_GOOD_BITS);
  localparam logic [8:0] LOOP_LAST = 9'(`MRC_LOOP_BITS - 1);
  localparam logic [6:0] COL_LAST = 7'(`MRC_COL_LIMIT - 1);
  localparam logic [1:0] LINK_LAST = 2'(`MRC_LINK_LIMIT - 1);
  localparam logic [2:0] GOOD_TX_LAST = 3'(`MRC_GOOD_TX - 1);
  localparam logic [LCW-1:0] LONG_COL = LCW'(LONG_COL_CYC);

  if (PORTS < 2 || PORTS > 16 || FIFO_DEPTH < 4 || (1 << AW) != FIFO_DEPTH
      || BIT_CYC < 2 || IPG_BITS < 1 || IPG_BITS > 1023) begin : g_bad_params
    $error("mrc_core: unsupported parameter values");
  end

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  function automatic logic [AW:0] from_gray(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ b[i+1];
    end
    return b;
  endfunction : from_gray

  function automatic logic [SW-1:0] first_port(input logic [PORTS-1:0] m);
    logic [SW-1:0] r;
    r = '0;
    for (int i = PORTS - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = SW'(i);
      end
    end
    return r;
  endfunction : first_port

  // Receive clock domain
  logic rx_prev_reg;
  logic rx_sfd_reg;
  logic [AW:0] wr_bin_reg;
  logic [AW:0] wr_gray_reg;
  logic [AW:0] rd_g_meta_reg;
  logic [AW:0] rd_g_sync_reg;
  logic [AW:0] rd_bin_rx;
  logic rx_full;
  logic rx_wr;

  assign rd_bin_rx = from_gray(rd_g_sync_reg);
  assign rx_full = (wr_bin_reg[AW] != rd_bin_rx[AW]) && (wr_bin_reg[AW-1:0] == rd_bin_rx[AW-1:0]);
  // Preamble alternates, so the first pair of ones marks its end
  assign rx_wr = rx_sfd_reg && i_rx_dv && !rx_full;

  always_ff @(posedge i_rx_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_g_meta_reg <= '0;
      rd_g_sync_reg <= '0;
    end else begin
      rd_g_meta_reg <= rd_gray_reg;
      rd_g_sync_reg <= rd_g_meta_reg;
    end
  end

  // Hunt restarts on the decoder's own valid, since this clock may stop
  always_ff @(posedge i_rx_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_prev_reg <= 1'b0;
      rx_sfd_reg <= 1'b0;
    end else if (!i_rx_dv) begin
      rx_prev_reg <= 1'b0;
      rx_sfd_reg <= 1'b0;
    end else begin
      rx_prev_reg <= i_rx_data;
      if (rx_prev_reg && i_rx_data) begin
        rx_sfd_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_rx_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_bin_reg <= '0;
      wr_gray_reg <= '0;
    end else if (rx_wr) begin
      wr_bin_reg <= wr_bin_reg + 1'b1;
      wr_gray_reg <= to_gray(wr_bin_reg + 1'b1);
    end
  end

  // Transmit clock domain
  logic [PORTS-1:0] car_meta_reg, car_s_reg;
  logic [PORTS-1:0] col_meta_reg, col_s_reg;
  logic [AW:0] wr_g_meta_reg, wr_g_sync_reg;
  logic [AW:0] wr_bin_tx;
  logic [AW:0] rd_bin_reg;
  logic [AW:0] rd_gray_reg;
  logic rd_data;
  logic fifo_empty;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      car_meta_reg <= '0;
      car_s_reg <= '0;
      col_meta_reg <= '0;
      col_s_reg <= '0;
      wr_g_meta_reg <= '0;
      wr_g_sync_reg <= '0;
    end else begin
      car_meta_reg <= i_carrier;
      car_s_reg <= car_meta_reg;
      col_meta_reg <= i_collision;
      col_s_reg <= col_meta_reg;
      wr_g_meta_reg <= wr_gray_reg;
      wr_g_sync_reg <= wr_g_meta_reg;
    end
  end

  assign wr_bin_tx = from_gray(wr_g_sync_reg);
  assign fifo_empty = (rd_bin_reg == wr_bin_tx);

  mrc_fifo_mem #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_mem (
    .i_wr_clk(i_rx_clk),
    .i_wr_en(rx_wr),
    .i_wr_addr(wr_bin_reg[AW-1:0]),
    .i_wr_data(i_rx_data),
    .i_rd_clk(i_clk),
    .i_rd_reset(i_reset),
    .i_rd_addr(rd_bin_reg[AW-1:0]),
    .o_rd_data(rd_data)
  );

  // Bit-time pacing for the encoder
  logic [3:0] div_reg;
  logic tick;
  assign tick = (div_reg == 4'(BIT_CYC - 1));

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      div_reg <= '0;
    end else begin
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;
    end
  end

  // Partitioned ports cannot win arbitration nor trigger enforcement
  logic [PORTS-1:0] part_reg;
  logic [PORTS-1:0] rx_cand;
  logic [PORTS-1:0] col_vis;
  logic [PORTS-1:0] rx_onehot;
  logic [SW-1:0] rx_port_reg;
  mrc_state_e state_reg, state_next;
  logic [9:0] bits_reg;
  logic [9:0] frame_bits_reg;
  logic frame_end;
  logic frame_start;

  assign rx_cand = car_s_reg & ~part_reg;
  assign col_vis = col_s_reg & ~part_reg;
  assign rx_onehot = PORTS'(1) << rx_port_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MRC_IDLE: begin
        if (|rx_cand) begin
          state_next = MRC_PRE;
        end
      end
      MRC_PRE: begin
        if (|col_vis) begin
          state_next = MRC_JAM;
        end else if (tick && bits_reg == PRE_LAST) begin
          state_next = MRC_DATA;
        end
      end
      MRC_DATA: begin
        if (|col_vis) begin
          state_next = MRC_JAM;
        end else if (tick && fifo_empty && !(|(car_s_reg & rx_onehot))) begin
          state_next = MRC_WAIT;
        end
      end
      MRC_JAM: begin
        if (tick && bits_reg >= JAM_LAST && !(|col_vis)) begin
          state_next = MRC_WAIT;
        end
      end
      MRC_WAIT: begin
        if (tick && bits_reg == IPG_LAST) begin
          state_next = MRC_IDLE;
        end
      end
      default: state_next = MRC_IDLE;
    endcase
  end

  assign frame_start = (state_reg == MRC_IDLE) && (state_next == MRC_PRE);
  assign frame_end = (state_reg != MRC_WAIT) && (state_next == MRC_WAIT);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= MRC_IDLE;
      bits_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        bits_reg <= '0;
      end else if (tick && bits_reg != 10'h3ff) begin
        bits_reg <= bits_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      frame_bits_reg <= '0;
    end else if (frame_start) begin
      frame_bits_reg <= '0;
    end else if (tick && frame_bits_reg < GOOD_BITS) begin
      frame_bits_reg <= frame_bits_reg + 10'h001;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_port_reg <= SW'(`MRC_AUI_PORT);
      o_rx_sel <= SW'(`MRC_AUI_PORT);
    end else if (frame_start) begin
      rx_port_reg <= first_port(rx_cand);
      o_rx_sel <= first_port(rx_cand);
    end
  end

  // Stale bits from an earlier frame are dropped at frame start
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_bin_reg <= '0;
      rd_gray_reg <= '0;
    end else if (frame_start) begin
      rd_bin_reg <= wr_bin_tx;
      rd_gray_reg <= wr_g_sync_reg;
    end else if (state_reg == MRC_DATA && tick && !fifo_empty) begin
      rd_bin_reg <= rd_bin_reg + 1'b1;
      rd_gray_reg <= to_gray(rd_bin_reg + 1'b1);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_tx_en <= '0;
    end else if (frame_start) begin
      o_tx_en <= ~(PORTS'(1) << first_port(rx_cand));
    end else if (state_reg != MRC_JAM && state_next == MRC_JAM) begin
      o_tx_en <= ~col_vis;
    end else if (state_reg == MRC_WAIT || state_reg == MRC_IDLE) begin
      // Held through the closing jam strobe, dropped once the quiet interval starts
      o_tx_en <= '0;
    end
  end

  // Underrun repeats the last bit rather than inventing a pattern
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_tx_data <= 1'b0;
      o_tx_strobe <= 1'b0;
    end else begin
      o_tx_strobe <= tick && (state_reg == MRC_PRE || state_reg == MRC_JAM
                              || (state_reg == MRC_DATA && state_next != MRC_WAIT));
      if (tick) begin
        unique case (state_reg)
          MRC_PRE: o_tx_data <= (bits_reg >= SFD_POS) ? 1'b1 : ~bits_reg[0];
          MRC_DATA: o_tx_data <= fifo_empty ? o_tx_data : rd_data;
          MRC_JAM: o_tx_data <= ~bits_reg[0];
          default: o_tx_data <= 1'b0;
        endcase
      end
    end
  end

  // Automatic partition and reconnection
  mrc_port_s stat_reg [PORTS];
  logic [6:0] col_cnt_reg [PORTS];
  logic [1:0] lf_cnt_reg [PORTS];
  logic [2:0] good_cnt_reg [PORTS];
  logic [8:0] loop_cnt_reg [PORTS];
  logic [LCW-1:0] lcol_cnt_reg [PORTS];
  logic [PORTS-1:0] link_part_reg;
  logic sending;

  assign sending = (state_reg == MRC_PRE) || (state_reg == MRC_DATA);
  assign o_partitioned = part_reg;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      part_reg <= '0;
      link_part_reg <= '0;
      for (int p = 0; p < PORTS; p++) begin
        stat_reg[p] <= '0;
        col_cnt_reg[p] <= '0;
        lf_cnt_reg[p] <= '0;
        good_cnt_reg[p] <= '0;
        loop_cnt_reg[p] <= '0;
        lcol_cnt_reg[p] <= '0;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        logic set_gen;
        logic set_link;
        logic clr;
        logic tx_p;
        set_gen = 1'b0;
        set_link = 1'b0;
        clr = 1'b0;
        tx_p = o_tx_en[p] && sending;

        if (col_s_reg[p]) begin
          if (lcol_cnt_reg[p] <= LONG_COL) begin
            lcol_cnt_reg[p] <= lcol_cnt_reg[p] + 1'b1;
          end else begin
            set_gen = 1'b1;
          end
        end else begin
          lcol_cnt_reg[p] <= '0;
        end

        if (frame_start) begin
          stat_reg[p] <= '0;
          loop_cnt_reg[p] <= '0;
        end else begin
          if (tx_p) begin
            stat_reg[p].tx <= 1'b1;
            if (car_s_reg[p]) begin
              stat_reg[p].car <= 1'b1;
            end else if (stat_reg[p].car && !col_s_reg[p]) begin
              stat_reg[p].lf <= 1'b1;
            end
            if (!stat_reg[p].car && !car_s_reg[p] && tick) begin
              loop_cnt_reg[p] <= loop_cnt_reg[p] + 9'h001;
              if (loop_cnt_reg[p] == LOOP_LAST) begin
                set_gen = 1'b1;
              end
            end
          end
          if (col_s_reg[p] && state_reg != MRC_IDLE) begin
            stat_reg[p].col <= 1'b1;
          end
        end

        if (col_s_reg[p] && link_part_reg[p]) begin
          clr = 1'b1;
        end

        if (frame_end) begin
          if (stat_reg[p].col || col_s_reg[p]) begin
            if (col_cnt_reg[p] == COL_LAST) begin
              set_gen = 1'b1;
            end else begin
              col_cnt_reg[p] <= col_cnt_reg[p] + 7'h01;
            end
            lf_cnt_reg[p] <= '0;
          end else if (stat_reg[p].tx) begin
            col_cnt_reg[p] <= '0;
            if (stat_reg[p].lf) begin
              good_cnt_reg[p] <= '0;
              if (lf_cnt_reg[p] == LINK_LAST) begin
                set_link = 1'b1;
                lf_cnt_reg[p] <= '0;
              end else begin
                lf_cnt_reg[p] <= lf_cnt_reg[p] + 2'h1;
              end
            end else begin
              lf_cnt_reg[p] <= '0;
              if (link_part_reg[p]) begin
                if (good_cnt_reg[p] == GOOD_TX_LAST) begin
                  clr = 1'b1;
                  good_cnt_reg[p] <= '0;
                end else begin
                  good_cnt_reg[p] <= good_cnt_reg[p] + 3'h1;
                end
              end else if (part_reg[p] && stat_reg[p].car
                           && frame_bits_reg >= GOOD_BITS) begin
                clr = 1'b1;
              end
            end
          end
        end

        // A new fault in the same cycle beats a reconnection
        if (set_gen || set_link) begin
          part_reg[p] <= 1'b1;
          link_part_reg[p] <= set_link && !part_reg[p];
          good_cnt_reg[p] <= '0;
        end else if (clr) begin
          part_reg[p] <= 1'b0;
          link_part_reg[p] <= 1'b0;
        end
      end
    end
  end

endmodule : mrc_core

`default_nettype wire

// ---- sim/mrc_core_asserts.sv ----
// Concurrent checks on the repeater core ports
`timescale 1ns/10ps
`default_nettype none

module mrc_core_asserts #(
  parameter int PORTS = 9,
  parameter int IPG_BITS = 96,
  parameter int LONG_COL_CYC = 8000
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [PORTS-1:0] i_collision,
  input wire logic [$clog2(PORTS)-1:0] o_rx_sel,
  input wire logic [PORTS-1:0] o_tx_en,
  input wire logic o_tx_data,
  input wire logic o_tx_strobe,
  input wire logic [PORTS-1:0] o_partitioned
);
  logic active;
  logic [15:0] gap_reg;
  logic [15:0] col_cnt_reg;
  logic [PORTS-1:0] col_prev_reg;
  logic [PORTS-1:0] part_prev_reg;

  assign active = |o_tx_en;

  // Saturates so the first frame after reset never looks like a short gap
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      gap_reg <= 16'hffff;
    end else if (active) begin
      gap_reg <= 16'h0000;
    end else if (gap_reg != 16'hffff) begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      col_cnt_reg <= 16'h0000;
    end else if (i_collision != '0 && i_collision == col_prev_reg) begin
      col_cnt_reg <= (col_cnt_reg == 16'hffff) ? col_cnt_reg : col_cnt_reg + 16'h0001;
    end else begin
      col_cnt_reg <= 16'h0000;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      col_prev_reg <= '0;
      part_prev_reg <= '0;
    end else begin
      col_prev_reg <= i_collision;
      part_prev_reg <= o_partitioned;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_first_one;
    ##[1:5] (o_tx_strobe && o_tx_data);
  endsequence
  sequence s_then_zero;
    o_tx_strobe && !o_tx_data;
  endsequence

  chk_preamble_start: assert property ($rose(active) |-> s_first_one ##4 s_then_zero)
    else $error("preamble does not open with 1 then 0");
  chk_strobe_gap: assert property (o_tx_strobe |=> !o_tx_strobe [*3])
    else $error("bit strobes closer than four clocks");
  chk_strobe_frame: assert property (o_tx_strobe |-> active)
    else $error("bit strobe with no port selected");
  chk_start_ports: assert property ($rose(active) |->
    !o_tx_en[o_rx_sel] && $countones(o_tx_en) == PORTS - 1)
    else $error("frame start does not drive all other ports");
  chk_sel_hold: assert property (active && $past(active) |-> $stable(o_rx_sel))
    else $error("receive select moved inside a frame");
  chk_part_no_rx: assert property ($rose(active) |-> !part_prev_reg[o_rx_sel])
    else $error("partitioned port was repeated");
  chk_ipg_gap: assert property ($rose(active) |-> gap_reg >= IPG_BITS * 4)
    else $error("wait interval after a frame too short");
  chk_data_hold: assert property (o_tx_strobe && active |=>
    ($stable(o_tx_data) || !active) [*3])
    else $error("transmit bit changed between strobes");
  chk_long_col: assert property (col_cnt_reg == LONG_COL_CYC + 6 |->
    (o_partitioned & col_prev_reg) == col_prev_reg)
    else $error("long collision did not partition the port");
endmodule : mrc_core_asserts

bind mrc_core mrc_core_asserts #(
  .PORTS(PORTS),
  .IPG_BITS(IPG_BITS),
  .LONG_COL_CYC(LONG_COL_CYC)
) u_chk (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_collision(i_collision),
  .o_rx_sel(o_rx_sel),
  .o_tx_en(o_tx_en),
  .o_tx_data(o_tx_data),
  .o_tx_strobe(o_tx_strobe),
  .o_partitioned(o_partitioned)
);

`default_nettype wire

// ---- sim/mrc_port_model.sv ----
// Behavioural transceivers and decoder on the far side of the repeater core
`timescale 1ns/10ps
`default_nettype none

module mrc_port_model (
  input wire logic i_clk,
  input wire logic [8:0] i_tx_en,
  output logic [8:0] o_carrier,
  output logic [8:0] o_collision,
  output logic o_rx_clk,
  output logic o_rx_data,
  output logic o_rx_dv
);
  logic [8:0] rx_car = 9'h000;
  logic [8:0] loop_off = 9'h000;

  // A driven transceiver echoes carrier unless the bench breaks its loopback
  assign o_carrier = rx_car | (i_tx_en & ~loop_off);

  initial begin
    o_collision = 9'h000;
    o_rx_clk = 1'b0;
    o_rx_data = 1'b0;
    o_rx_dv = 1'b0;
  end

  // Short preamble on purpose; recovered clock runs three bits past the frame, then stops
  task automatic send(input int p, input logic [15:0] d, input int hold_ns);
    logic [23:0] bits;
    int i;
    bits = {8'hab, d};
    rx_car[p] = 1'b1;
    #207;
    for (i = 23; i >= 0; i--) begin
      o_rx_data = bits[i];
      o_rx_dv = 1'b1;
      #15 o_rx_clk = 1'b1;
      #15 o_rx_clk = 1'b0;
    end
    o_rx_dv = 1'b0;
    repeat (3) begin
      #15 o_rx_clk = 1'b1;
      #15 o_rx_clk = 1'b0;
    end
    o_rx_data = ~o_rx_data;
    #(hold_ns);
    rx_car[p] = 1'b0;
  endtask : send

  task automatic collide(input int p, input int n);
    o_collision[p] = 1'b1;
    repeat (n) @(posedge i_clk);
    #1 o_collision[p] = 1'b0;
  endtask : collide
endmodule : mrc_port_model

`default_nettype wire

// ---- sim/mrc_core_tb.sv ----
// Self-checking bench for the repeater core
`timescale 1ns/10ps
`default_nettype none

module mrc_core_tb;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  wire logic rx_clk, rx_data, rx_dv;
  wire logic [8:0] carrier, collision;
  logic [3:0] o_rx_sel;
  logic [8:0] o_tx_en, o_partitioned;
  logic o_tx_data, o_tx_strobe;
  logic cap [0:4095];
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int ncap = 0;

  always #12.5 i_clk = ~i_clk;

  mrc_core #(.LONG_COL_CYC(40)) u_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_rx_clk(rx_clk), .i_rx_data(rx_data),
    .i_rx_dv(rx_dv), .i_carrier(carrier), .i_collision(collision),
    .o_rx_sel(o_rx_sel), .o_tx_en(o_tx_en), .o_tx_data(o_tx_data),
    .o_tx_strobe(o_tx_strobe), .o_partitioned(o_partitioned)
  );

  mrc_port_model u_model (
    .i_clk(i_clk), .i_tx_en(o_tx_en), .o_carrier(carrier), .o_collision(collision),
    .o_rx_clk(rx_clk), .o_rx_data(rx_data), .o_rx_dv(rx_dv)
  );

  task test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // Hang guard: all tests need well under half of this
  always @(posedge i_clk) begin
    cycles++;
    if (o_tx_strobe === 1'b1 && ncap < 4096) begin
      cap[ncap] = o_tx_data;
      ncap++;
    end
    if (cycles == 40000) begin
      n_mismatch++;
      test_done();
    end
  end

  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic start(input int p, input logic [15:0] d, input int hold);
    fork
      u_model.send(p, d, hold);
    join_none
  endtask : start

  task automatic wait_start;
    int k;
    k = 0;
    while (o_tx_en === 9'h000 && k < 60) begin
      @(posedge i_clk);
      #1 k++;
    end
  endtask : wait_start

  // Waits out the frame and the quiet interval that follows it
  task automatic wait_end;
    int k;
    k = 0;
    while (o_tx_en !== 9'h000 && k < 8000) begin
      @(posedge i_clk);
      #1 k++;
    end
    repeat (420) @(posedge i_clk);
    #1;
  endtask : wait_end

  task automatic t_basic;
    logic [63:0] pre;
    logic [15:0] d;
    int i;
    ncap = 0;
    start(3, 16'hc35a, 1000);
    wait_start();
    chk(o_rx_sel, 64'h3);
    chk(o_tx_en, 64'h1f7);
    wait_end();
    for (i = 0; i < 64; i++) begin
      pre[63 - i] = cap[i];
    end
    for (i = 0; i < 16; i++) begin
      d[15 - i] = cap[64 + i];
    end
    chk(pre, 64'haaaaaaaaaaaaaaab);
    chk(d, 64'hc35a);
    $display("test basic done");
  endtask : t_basic

  // One strobe may fall before the mask is checked, hence 95
  task automatic jam_case(input int rx, input int cp, input logic [8:0] exp);
    int n0;
    start(rx, 16'h0ff0, 1000);
    wait_start();
    repeat (40) @(posedge i_clk);
    #1;
    fork
      u_model.collide(cp, 20);
    join_none
    repeat (6) @(posedge i_clk);
    #1 chk(o_tx_en, exp);
    n0 = ncap;
    wait_end();
    chk(ncap - n0 >= 95, 64'h1);
  endtask : jam_case

  task automatic t_txcol;
    jam_case(1, 5, 9'h1df);
    $display("test transmit collision done");
  endtask : t_txcol

  task automatic t_rxcol;
    jam_case(6, 6, 9'h1bf);
    $display("test receive collision done");
  endtask : t_rxcol

  task automatic t_loop;
    u_model.loop_off = 9'h080;
    start(2, 16'h1234, 30000);
    wait_start();
    wait_end();
    chk(o_partitioned, 64'h080);
    u_model.rx_car[7] = 1'b1;
    repeat (100) @(posedge i_clk);
    #1 chk(o_tx_en, 64'h0);
    u_model.rx_car[7] = 1'b0;
    u_model.loop_off = 9'h000;
    repeat (10) @(posedge i_clk);
    #1 start(4, 16'h5a5a, 60000);
    wait_start();
    chk(o_tx_en, 64'h1ef);
    wait_end();
    chk(o_partitioned, 64'h0);
    $display("test loopback partition done");
  endtask : t_loop

  // Carrier cut mid-frame on port 5, twice, then a collision brings it back
  task automatic t_link;
    repeat (2) begin
      start(1, 16'h0f0f, 1000);
      wait_start();
      repeat (20) @(posedge i_clk);
      #1 u_model.loop_off = 9'h020;
      wait_end();
      u_model.loop_off = 9'h000;
    end
    chk(o_partitioned, 64'h020);
    u_model.collide(5, 4);
    repeat (4) @(posedge i_clk);
    #1 chk(o_partitioned, 64'h0);
    $display("test link fault done");
  endtask : t_link

  task automatic t_longcol;
    u_model.collide(2, 60);
    repeat (2) @(posedge i_clk);
    #1 chk(o_partitioned, 64'h004);
    $display("test long collision done");
  endtask : t_longcol

  initial begin
    repeat (6) @(posedge i_clk);
    #1 i_reset = 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    t_basic();
    t_txcol();
    t_rxcol();
    t_loop();
    t_link();
    t_longcol();
    test_done();
  end
endmodule : mrc_core_tb

`default_nettype wire
